// ---- bus_pin_function_control.sv ----
// Implementation choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module bus_pin_function_control
  import pinfn_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Operating mode and bus controller
  input wire logic ext_mode,
  input wire logic [15:0] bus_addr,
  input wire logic bus_grant,
  output logic ext_bus_req,
  output logic ext_wait,
  // Watchdog clock sources
  input wire wdt_ticks_t wdt_ticks,
  input wire logic prescaler_source_select,
  input wire logic [2:0] watchdog_clock_select,
  output logic buzzer_signal,
  // Upper address pins A8 to A23
  input wire addr_port_t addr_port,
  output logic [15:0] addr_pin_out,
  output logic [15:0] addr_pin_oe,
  // Request, grant, wait and port F1 pins
  input wire ctl_port_t ctl_port,
  input wire logic [3:0] ctl_pin_in,
  output logic [3:0] ctl_pin_out,
  output logic [3:0] ctl_pin_oe
);

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------

  // One-hot select: bit 0 control-low, bit 1 pin function
  function automatic logic [1:0] reg_sel(input logic [7:0] a);
    logic [1:0] s;
    s = 2'b00;
    if (a == BUS_CTRL_LOW_OFS) begin
      s = 2'b01;
    end else if (a == PIN_FUNC_OFS) begin
      s = 2'b10;
    end
    return s;
  endfunction : reg_sel

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------

  slave_state_t st_r;
  slave_state_t st_nxt;
  pin_cfg_t cfg;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic [7:0] wa;
  logic [7:0] wd;
  logic ws0;
  logic [1:0] wsel;
  logic [1:0] rsel;

  // Channel handshakes
  assign aw_hs = s_axi_awvalid & s_axi_awready;
  assign w_hs = s_axi_wvalid & s_axi_wready;
  assign ar_hs = s_axi_arvalid & s_axi_arready;

  // Address and data of the pending write, captured or live
  assign wa = st_r.aw_got ? st_r.awaddr : s_axi_awaddr;
  assign wd = st_r.w_got ? st_r.wdata : s_axi_wdata[7:0];
  assign ws0 = st_r.w_got ? st_r.wstrb0 : s_axi_wstrb[0];
  assign wsel = reg_sel(wa);
  assign rsel = reg_sel(s_axi_araddr);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------

  // Write and read channels, each one transfer at a time
  always_comb begin
    st_nxt = st_r;
    case (st_r.wr_st)
      WR_IDLE: begin
        if (aw_hs) begin
          st_nxt.aw_got = 1'b1;
          st_nxt.awaddr = s_axi_awaddr;
        end
        if (w_hs) begin
          st_nxt.w_got = 1'b1;
          st_nxt.wdata = s_axi_wdata[7:0];
          st_nxt.wstrb0 = s_axi_wstrb[0];
        end
        if ((st_r.aw_got | aw_hs) & (st_r.w_got | w_hs)) begin
          st_nxt.aw_got = 1'b0;
          st_nxt.w_got = 1'b0;
          st_nxt.wr_st = WR_RESP;
          st_nxt.bresp = (wsel == 2'b00) ? RESP_SLVERR : RESP_OKAY;
          // Bit 5 of control-low stays zero whatever is written
          if (wsel[0] & ws0) begin
            st_nxt.bcl = (wd & BUS_CTRL_LOW_WMASK) | (st_r.bcl & ~BUS_CTRL_LOW_WMASK);
          end
          if (wsel[1] & ws0) begin
            st_nxt.pfc = (wd & PIN_FUNC_WMASK) | (st_r.pfc & ~PIN_FUNC_WMASK);
          end
        end
      end
      WR_RESP: begin
        if (s_axi_bready) begin
          st_nxt.wr_st = WR_IDLE;
        end
      end
      default: begin
        st_nxt.wr_st = WR_IDLE;
      end
    endcase
    case (st_r.rd_st)
      RD_IDLE: begin
        if (ar_hs) begin
          st_nxt.rd_st = RD_DATA;
          st_nxt.rresp = RESP_OKAY;
          if (rsel[0]) begin
            st_nxt.rdata = st_r.bcl;
          end else if (rsel[1]) begin
            st_nxt.rdata = st_r.pfc;
          end else begin
            st_nxt.rdata = 8'h00;
            st_nxt.rresp = RESP_SLVERR;
          end
        end
      end
      RD_DATA: begin
        if (s_axi_rready) begin
          st_nxt.rd_st = RD_IDLE;
        end
      end
      default: begin
        st_nxt.rd_st = RD_IDLE;
      end
    endcase
  end

  // Register the state; reset loads the documented defaults
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.bcl <= BUS_CTRL_LOW_RST;
      st_r.pfc <= PIN_FUNC_RST;
      st_r.wr_st <= WR_IDLE;
      st_r.rd_st <= RD_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Bus outputs
  // ---------------------------------------------------------------

  // Ready while idle and the channel is not already held
  assign s_axi_awready = (st_r.wr_st == WR_IDLE) & ~st_r.aw_got;
  assign s_axi_wready = (st_r.wr_st == WR_IDLE) & ~st_r.w_got;
  assign s_axi_bvalid = (st_r.wr_st == WR_RESP);
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = (st_r.rd_st == RD_IDLE);
  assign s_axi_rvalid = (st_r.rd_st == RD_DATA);
  assign s_axi_rresp = st_r.rresp;
  assign s_axi_rdata = {24'h000000, st_r.rdata};

  // ---------------------------------------------------------------
  // Pin functions
  // ---------------------------------------------------------------

  // Configuration bits steering the pin muxes
  assign cfg.release_en = st_r.bcl[BUS_RELEASE_ENABLE_BIT];
  assign cfg.wait_en = st_r.bcl[WAIT_PIN_ENABLE_BIT];
  assign cfg.buzzer_signal_en = st_r.pfc[BUZZER_OUTPUT_ENABLE_BIT];
  assign cfg.addr_field = st_r.pfc[ADDR_FIELD_MSB:ADDR_FIELD_LSB];

  // Upper address pins
  addr_pin_mux u_addr (
    .ext_mode(ext_mode),
    .addr_field(cfg.addr_field),
    .bus_addr(bus_addr),
    .addr_port(addr_port),
    .addr_pin_out(addr_pin_out),
    .addr_pin_oe(addr_pin_oe)
  );

  // Release, wait and buzzer pins
  pin_role_mux u_roles (
    .cfg(cfg),
    .bus_grant(bus_grant),
    .wdt_ticks(wdt_ticks),
    .prescaler_source_select(prescaler_source_select),
    .watchdog_clock_select(watchdog_clock_select),
    .ext_bus_req(ext_bus_req),
    .ext_wait(ext_wait),
    .buzzer_signal(buzzer_signal),
    .ctl_port(ctl_port),
    .ctl_pin_in(ctl_pin_in),
    .ctl_pin_out(ctl_pin_out),
    .ctl_pin_oe(ctl_pin_oe)
  );

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  logic wr_commit;
  assign wr_commit = (st_r.wr_st == WR_IDLE) & (st_r.aw_got | aw_hs) & (st_r.w_got | w_hs);

  // Release bit written one opens request path next cycle
  property p_release_write;
    (wr_commit && wsel[0] && ws0 && wd[7]) |=> cfg.release_en ##0
      (ctl_pin_in[PIN_BUS_REQ] || ext_bus_req);
  endproperty
  a_release_write: assert property (p_release_write)
    else $error("release enable not applied");

  // Without release, request and grant pins follow port bits
  property p_release_off_port;
    !cfg.release_en |-> (ctl_pin_oe[1:0] == ctl_port.ddr[1:0]) && !ext_bus_req;
  endproperty
  a_release_off_port: assert property (p_release_off_port)
    else $error("request or grant pin not a port");

  // Reading control-low never shows bit 5
  property p_fixed_zero;
    (ar_hs && rsel[0]) |=> s_axi_rvalid && !s_axi_rdata[BCL_FIXED_ZERO_BIT]
      && (s_axi_rresp == RESP_OKAY);
  endproperty
  a_fixed_zero: assert property (p_fixed_zero)
    else $error("control-low bit 5 read as one");

  // Wait pin only reaches the core while enabled
  property p_wait_gate;
    (!ctl_pin_in[PIN_WAIT]) |-> (ext_wait == cfg.wait_en)
      && (ctl_pin_oe[PIN_WAIT] == (!cfg.wait_en && ctl_port.ddr[PIN_WAIT]));
  endproperty
  a_wait_gate: assert property (p_wait_gate)
    else $error("wait pin gating wrong");

  // Port F1 carries the buzzer while enabled
  property p_buzzer_pin;
    cfg.buzzer_signal_en |-> ctl_pin_oe[PIN_PORT_F1] && (ctl_pin_out[PIN_PORT_F1] == buzzer_signal);
  endproperty
  a_buzzer_pin: assert property (p_buzzer_pin)
    else $error("buzzer not on port F1");

  // Buzzer equals the selected watchdog clock tap
  property p_buzzer_src;
    buzzer_signal == (prescaler_source_select ? wdt_ticks.set_b[watchdog_clock_select]
      : wdt_ticks.set_a[watchdog_clock_select]);
  endproperty
  a_buzzer_src: assert property (p_buzzer_src)
    else $error("buzzer source wrong");

  // In extended mode the lowest n pins carry the address, all 16 for n = 15
  property p_addr_span;
    ext_mode |-> ((addr_pin_oe ^ addr_en_mask(cfg.addr_field)) & ~addr_port.ddr) == 16'h0000;
  endproperty
  a_addr_span: assert property (p_addr_span)
    else $error("address span wrong");

  // Field all ones drives every pin A8 to A23
  property p_addr_full;
    (ext_mode && cfg.addr_field == 4'hf) |-> addr_pin_oe == 16'hffff;
  endproperty
  a_addr_full: assert property (p_addr_full)
    else $error("field all ones leaves a pin undriven");

  // Field zero leaves every pin to its direction bit
  property p_addr_none;
    (ext_mode && cfg.addr_field == 4'h0) |-> addr_pin_oe == addr_port.ddr;
  endproperty
  a_addr_none: assert property (p_addr_none)
    else $error("field zero drives an address pin");

  // Enabled pins drive the address regardless of direction
  property p_addr_drive;
    ext_mode |-> ((addr_pin_out ^ bus_addr) & addr_en_mask(cfg.addr_field)) == 16'h0000;
  endproperty
  a_addr_drive: assert property (p_addr_drive)
    else $error("enabled pin not driving address");

  // Outside extended mode every address pin is a plain port
  property p_addr_port;
    !ext_mode |-> (addr_pin_oe == addr_port.ddr) && (addr_pin_out == addr_port.dr);
  endproperty
  a_addr_port: assert property (p_addr_port)
    else $error("address pin not a port");

  // A written byte lands in the pin function register
  property p_readback;
    (wr_commit && wsel[1] && ws0) |=> st_r.pfc == $past(wd);
  endproperty
  a_readback: assert property (p_readback)
    else $error("pin function readback wrong");

  // Write response one cycle after the later handshake
  property p_bresp_time;
    wr_commit |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready;
  endproperty
  a_bresp_time: assert property (p_bresp_time)
    else $error("write response late");

  c_release_on: cover property (wr_commit && wsel[0] && wd[7]);
  c_buzzer_on: cover property (cfg.buzzer_signal_en && ctl_pin_out[PIN_PORT_F1]);
  c_full_addr: cover property (ext_mode && cfg.addr_field == 4'hf);
  c_bad_addr: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);

endmodule : bus_pin_function_control
`default_nettype wire

// ---- pinfn_pkg.sv ----
package pinfn_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] BUS_CTRL_LOW_OFS = 8'h00;
  localparam logic [7:0] PIN_FUNC_OFS = 8'h04;
  localparam logic [7:0] BUS_CTRL_LOW_RST = 8'h08;
  localparam logic [7:0] PIN_FUNC_RST = 8'h00;
  localparam logic [7:0] BUS_CTRL_LOW_WMASK = 8'hdf;
  localparam logic [7:0] PIN_FUNC_WMASK = 8'hff;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int BUS_RELEASE_ENABLE_BIT = 7;
  localparam int BCL_FIXED_ZERO_BIT = 5;
  localparam int WAIT_PIN_ENABLE_BIT = 0;
  localparam int BUZZER_OUTPUT_ENABLE_BIT = 5;
  localparam int ADDR_FIELD_LSB = 0;
  localparam int ADDR_FIELD_MSB = 3;

  // ---------------------------------------------------------------
  // Pin groups and bus answers
  // ---------------------------------------------------------------
  localparam int ADDR_PINS = 16;
  localparam int PIN_BUS_REQ = 0;
  localparam int PIN_BUS_GRANT = 1;
  localparam int PIN_WAIT = 2;
  localparam int PIN_PORT_F1 = 3;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic {WR_IDLE = 1'b0, WR_RESP = 1'b1} wr_state_t;
  typedef enum logic {RD_IDLE = 1'b0, RD_DATA = 1'b1} rd_state_t;

  typedef struct packed {
    logic [15:0] ddr;
    logic [15:0] dr;
  } addr_port_t;

  typedef struct packed {
    logic [3:0] ddr;
    logic [3:0] dr;
  } ctl_port_t;

  typedef struct packed {
    logic [7:0] set_b;
    logic [7:0] set_a;
  } wdt_ticks_t;

  typedef struct packed {
    logic release_en;
    logic wait_en;
    logic buzzer_signal_en;
    logic [3:0] addr_field;
  } pin_cfg_t;

  typedef struct packed {
    logic [7:0] bcl;
    logic [7:0] pfc;
    wr_state_t wr_st;
    rd_state_t rd_st;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [7:0] wdata;
    logic wstrb0;
    logic [1:0] bresp;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } slave_state_t;

  // Field value n enables the lowest n upper address pins, all 16 for n = 15
  function automatic logic [15:0] addr_en_mask(input logic [3:0] n);
    logic [15:0] m;
    m = 16'h0000;
    for (int i = 0; i < ADDR_PINS; i++) begin
      m[i] = (5'(i) < {1'b0, n}) || (n == 4'hf);
    end
    return m;
  endfunction : addr_en_mask

endpackage : pinfn_pkg

// ---- addr_pin_mux.sv ----
`timescale 1ns/1ps
`default_nettype none
module addr_pin_mux
  import pinfn_pkg::*;
(
  // Configuration
  input wire logic ext_mode,
  input wire logic [3:0] addr_field,
  // Address and port sources
  input wire logic [15:0] bus_addr,
  input wire addr_port_t addr_port,
  // Pin drive
  output logic [15:0] addr_pin_out,
  output logic [15:0] addr_pin_oe
);

  logic [15:0] en;

  // Field only acts in extended mode
  assign en = ext_mode ? addr_en_mask(addr_field) : 16'h0000;

  // Address wins over direction bit; else port output or input
  always_comb begin
    for (int i = 0; i < ADDR_PINS; i++) begin
      addr_pin_out[i] = en[i] ? bus_addr[i] : addr_port.dr[i];
      addr_pin_oe[i] = en[i] | addr_port.ddr[i];
    end
  end

endmodule : addr_pin_mux
`default_nettype wire

// ---- pin_role_mux.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_role_mux
  import pinfn_pkg::*;
(
  // Configuration
  input wire pin_cfg_t cfg,
  // Core side
  input wire logic bus_grant,
  input wire wdt_ticks_t wdt_ticks,
  input wire logic prescaler_source_select,
  input wire logic [2:0] watchdog_clock_select,
  output logic ext_bus_req,
  output logic ext_wait,
  output logic buzzer_signal,
  // Pins and their port bits
  input wire ctl_port_t ctl_port,
  input wire logic [3:0] ctl_pin_in,
  output logic [3:0] ctl_pin_out,
  output logic [3:0] ctl_pin_oe
);

  // Buzzer carries the chosen watchdog input clock
  assign buzzer_signal = prescaler_source_select ?
    wdt_ticks.set_b[watchdog_clock_select] : wdt_ticks.set_a[watchdog_clock_select];

  // Pins pass to core only while their function is on
  assign ext_bus_req = cfg.release_en & ~ctl_pin_in[PIN_BUS_REQ];
  assign ext_wait = cfg.wait_en & ~ctl_pin_in[PIN_WAIT];

  // Pin roles, falling back to port bits when disabled
  always_comb begin
    ctl_pin_out = ctl_port.dr;
    ctl_pin_oe = ctl_port.ddr;
    if (cfg.release_en) begin
      ctl_pin_oe[PIN_BUS_REQ] = 1'b0;
      ctl_pin_out[PIN_BUS_GRANT] = ~bus_grant;
      ctl_pin_oe[PIN_BUS_GRANT] = 1'b1;
    end
    if (cfg.wait_en) begin
      ctl_pin_oe[PIN_WAIT] = 1'b0;
    end
    if (cfg.buzzer_signal_en) begin
      ctl_pin_out[PIN_PORT_F1] = buzzer_signal;
      ctl_pin_oe[PIN_PORT_F1] = 1'b1;
    end
  end

endmodule : pin_role_mux
`default_nettype wire

// ---- bus_pin_function_control_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module bus_pin_function_control_tb
  import pinfn_pkg::*;
;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic aclk, aresetn;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic ext_mode, bus_grant, ext_bus_req, ext_wait, prescaler_source_select, buzzer_signal;
  logic [15:0] bus_addr, addr_pin_out, addr_pin_oe;
  logic [2:0] watchdog_clock_select;
  wdt_ticks_t wdt_ticks;
  addr_port_t addr_port;
  ctl_port_t ctl_port;
  logic [3:0] ctl_pin_in, ctl_pin_out, ctl_pin_oe;
  int n_fail, n_tests;
  logic [31:0] seed;
  logic [7:0] bcl_m, pfc_m;

  bus_pin_function_control uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .ext_mode(ext_mode),
    .bus_addr(bus_addr), .bus_grant(bus_grant), .ext_bus_req(ext_bus_req),
    .ext_wait(ext_wait), .wdt_ticks(wdt_ticks),
    .prescaler_source_select(prescaler_source_select),
    .watchdog_clock_select(watchdog_clock_select), .buzzer_signal(buzzer_signal),
    .addr_port(addr_port), .addr_pin_out(addr_pin_out), .addr_pin_oe(addr_pin_oe),
    .ctl_port(ctl_port), .ctl_pin_in(ctl_pin_in), .ctl_pin_out(ctl_pin_out),
    .ctl_pin_oe(ctl_pin_oe));

  // Clock, 4 ns period
  always #2 aclk = ~aclk;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic timeout();
    n_fail++;
    $display("[ERR] t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
    summarize();
  endtask : timeout

  // Write one word; the model takes it as the rules say
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int k;
    logic ha, hw, hb;
    logic [1:0] r, er;
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_awvalid <= 1'b1; s_axi_wdata <= d; s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    for (k = 0; k < 64; k++) begin
      @(negedge aclk);
      ha = s_axi_awvalid & s_axi_awready;
      hw = s_axi_wvalid & s_axi_wready;
      hb = s_axi_bvalid & s_axi_bready;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
      if (hb) begin
        s_axi_bready <= 1'b0;
        break;
      end
    end
    if (k == 64) timeout();
    er = (a == BUS_CTRL_LOW_OFS || a == PIN_FUNC_OFS) ? RESP_OKAY : RESP_SLVERR;
    if (a == BUS_CTRL_LOW_OFS && s[0]) bcl_m = d[7:0] & 8'hdf;
    if (a == PIN_FUNC_OFS && s[0]) pfc_m = d[7:0];
    chk(32'(r), 32'(er));
  endtask : wr

  // Read one word and compare with the model
  task automatic rd(input logic [7:0] a);
    int k;
    logic ha, hr;
    logic [31:0] d, ed;
    logic [1:0] r, er;
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    for (k = 0; k < 64; k++) begin
      @(negedge aclk);
      ha = s_axi_arvalid & s_axi_arready;
      hr = s_axi_rvalid & s_axi_rready;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ha) s_axi_arvalid <= 1'b0;
      if (hr) begin
        s_axi_rready <= 1'b0;
        break;
      end
    end
    if (k == 64) timeout();
    ed = (a == BUS_CTRL_LOW_OFS) ? {24'h0, bcl_m} : (a == PIN_FUNC_OFS) ? {24'h0, pfc_m} : 32'h0;
    chk(d, ed);
    er = (a == BUS_CTRL_LOW_OFS || a == PIN_FUNC_OFS) ? RESP_OKAY : RESP_SLVERR;
    chk(32'(r), 32'(er));
  endtask : rd

  // Random pin inputs, then compare every pin against the model
  task automatic pins(input logic em);
    logic [15:0] m, eo;
    logic [3:0] co, cv;
    logic bz, rel, wt, bze;
    @(posedge aclk);
    ext_mode <= em;
    bus_addr <= 16'(rnd());
    bus_grant <= 1'(rnd());
    wdt_ticks <= 16'(rnd());
    prescaler_source_select <= 1'(rnd());
    watchdog_clock_select <= 3'(rnd());
    addr_port <= rnd();
    ctl_port <= 8'(rnd());
    ctl_pin_in <= 4'(rnd());
    @(negedge aclk);
    rel = bcl_m[7]; wt = bcl_m[0]; bze = pfc_m[5];
    m = 16'h0;
    for (int i = 0; i < 16; i++) m[i] = em && (i < pfc_m[3:0] || pfc_m[3:0] == 4'hf);
    eo = m | addr_port.ddr;
    chk(32'(addr_pin_oe), 32'(eo));
    chk(32'(addr_pin_out & eo), 32'(((m & bus_addr) | (~m & addr_port.dr)) & eo));
    chk(32'(addr_pin_out & m), 32'(bus_addr & m));
    bz = prescaler_source_select ? wdt_ticks.set_b[watchdog_clock_select]
                                 : wdt_ticks.set_a[watchdog_clock_select];
    chk(32'(buzzer_signal), 32'(bz));
    chk(32'(ext_bus_req), 32'(rel & ~ctl_pin_in[0]));
    chk(32'(ext_wait), 32'(wt & ~ctl_pin_in[2]));
    co = {bze | ctl_port.ddr[3], ~wt & ctl_port.ddr[2], rel | ctl_port.ddr[1],
          ~rel & ctl_port.ddr[0]};
    cv = {bze ? bz : ctl_port.dr[3], ctl_port.dr[2], rel ? ~bus_grant : ctl_port.dr[1],
          ctl_port.dr[0]};
    chk(32'(ctl_pin_oe), 32'(co));
    chk(32'(ctl_pin_out & co), 32'(cv & co));
  endtask : pins

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    aclk = 1'b0; aresetn = 1'b0; n_fail = 0; n_tests = 0; seed = 32'h96cd7b35;
    s_axi_awaddr = 8'h00; s_axi_awvalid = 1'b0; s_axi_wdata = 32'h0; s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0; s_axi_bready = 1'b0; s_axi_araddr = 8'h00; s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0; ext_mode = 1'b0; bus_addr = 16'h0; bus_grant = 1'b0;
    wdt_ticks = '0; prescaler_source_select = 1'b0; watchdog_clock_select = 3'h0;
    addr_port = '0; ctl_port = '0; ctl_pin_in = 4'hf;
    bcl_m = 8'h08; pfc_m = 8'h00;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    // Values after reset
    rd(BUS_CTRL_LOW_OFS);
    rd(PIN_FUNC_OFS);
    pins(1'b1);
    $display("test reset_values done");
    // Random control words, bit 3 set and reserved bits clear
    for (int i = 0; i < 40; i++) begin
      wr(BUS_CTRL_LOW_OFS, (rnd() & 32'ha1) | 32'h08, {3'h0, 1'(rnd())});
      rd(BUS_CTRL_LOW_OFS);
      wr(PIN_FUNC_OFS, rnd() & 32'h2f, {3'h0, 1'(rnd())});
      rd(PIN_FUNC_OFS);
      pins(1'(rnd()));
    end
    $display("test random_config done");
    // Every address field code in both modes
    for (int n = 0; n < 16; n++) begin
      wr(PIN_FUNC_OFS, 32'(n) | (rnd() & 32'h20), 4'h1);
      pins(1'b1);
      pins(1'b0);
    end
    $display("test addr_field_codes done");
    // Unmapped and masked accesses leave the registers alone
    wr(8'h08, 32'hff, 4'hf);
    rd(8'h0c);
    wr(BUS_CTRL_LOW_OFS, 32'h000000a9, 4'h0);
    rd(BUS_CTRL_LOW_OFS);
    rd(PIN_FUNC_OFS);
    $display("test unmapped_access done");
    // Reset in mid run restores the defaults
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    bcl_m = 8'h08;
    pfc_m = 8'h00;
    rd(BUS_CTRL_LOW_OFS);
    rd(PIN_FUNC_OFS);
    pins(1'b1);
    $display("test mid_reset done");
    summarize();
  end

endmodule : bus_pin_function_control_tb
`default_nettype wire
